//--- sep_defs.vh
// constants shared by the serial memory command port and its buffer
`ifndef SEP_DEFS_VH
`define SEP_DEFS_VH

// instruction field lengths, first bit on the wire lands in bit 0
`define SEP_ADDR_BITS      8
`define SEP_CMD_BITS       8
`define SEP_CMD_LAST       6'h0f
`define SEP_DATA_LAST_BYTE 6'h17
`define SEP_DATA_LAST_WORD 6'h1f
`define SEP_SHIFT_BYTE     5'h07
`define SEP_SHIFT_WORD     5'h0f

// command codes, C0 held in bit 0
`define SEP_CMD_READ       8'h01
`define SEP_CMD_PROGRAM    8'h06
`define SEP_CMD_ERASE      8'h0c
`define SEP_CMD_STATUS     8'h0d
`define SEP_CMD_UNLOCK     8'h09
`define SEP_CMD_LOCK       8'h0b

// storage
`define SEP_MEM_BYTES      256
`define SEP_ERASED         8'hff
`define SEP_WEN_RST        1'b0

// synchroniser order {cs_n, sclk, serial_in, word_width_select, low_supply}
`define SEP_PIN_RST        5'h18
`define SEP_PIN_CS         4
`define SEP_PIN_SCLK       3
`define SEP_PIN_DI         2
`define SEP_PIN_WIDE       1
`define SEP_PIN_LOW        0

// self-timed program and erase
`define SEP_CLK_PERIOD_NS  8
`define SEP_WRITE_TIME_MS  20
`define SEP_WRITE_CYCLES   (`SEP_WRITE_TIME_MS * 1000000 / `SEP_CLK_PERIOD_NS)
`define SEP_TIMER_W        22

// fetch buffer
`define SEP_BUF_W          16
`define SEP_BUF_DEPTH      2
`define SEP_BUF_AW         1

`endif

//--- sep_buf2.v
// two-entry valid/ready buffer between the word fetch and the shifter
`timescale 1ns/10ps
`include "sep_defs.vh"

module sep_buf2 #(
    parameter W     = `SEP_BUF_W,
    parameter DEPTH = `SEP_BUF_DEPTH,
    parameter AW    = `SEP_BUF_AW
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          arst_n,
    input  wire          clr,
    // filling side
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // draining side
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);

    reg  [W-1:0]  ent_q [0:DEPTH-1];
    reg  [AW-1:0] wr_q;
    reg  [AW-1:0] rd_q;
    reg  [AW:0]   cnt_q;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = ent_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            ent_q[wr_q] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (clr) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

endmodule

//--- sep_cmd_port.v
// serial memory command port: decoder, storage, self timer, read shifter
`timescale 1ns/10ps
`include "sep_defs.vh"

module sep_cmd_port #(
    parameter [`SEP_TIMER_W-1:0] WRITE_CYCLES = `SEP_WRITE_CYCLES
) (
    // clock and power-up reset
    input  wire  sys_clk,
    input  wire  arst_n,
    // serial pins
    input  wire  cs_n,
    input  wire  sclk,
    input  wire  serial_in,
    output wire  serial_out,
    output wire  serial_out_oe_n,
    // configuration and supply monitor
    input  wire  word_width_select,
    input  wire  low_supply,
    // status pin
    output wire  ready_status
);

    localparam [2:0] ST_HEAD = 3'd0;
    localparam [2:0] ST_DATA = 3'd1;
    localparam [2:0] ST_READ = 3'd2;
    localparam [2:0] ST_STAT = 3'd3;
    localparam [2:0] ST_DONE = 3'd4;

    // pin synchronisers
    reg  [4:0]                pin_s1_q;
    reg  [4:0]                pin_s2_q;
    reg                       sclk_d_q;
    reg                       wide_q;

    // instruction capture
    reg  [2:0]                st_q;
    reg  [5:0]                bit_cnt_q;
    reg  [7:0]                addr_sh_q;
    reg  [7:0]                cmd_sh_q;
    reg  [15:0]               data_sh_q;

    // write mode, timer, storage
    reg                       wen_q;
    reg                       ready_q;
    reg  [`SEP_TIMER_W-1:0]   tmr_q;
    reg  [7:0]                mem_q [0:`SEP_MEM_BYTES-1];

    // read path
    reg  [7:0]                fetch_addr_q;
    reg  [15:0]               out_sh_q;
    reg  [4:0]                out_cnt_q;
    reg                       so_q;
    reg                       oe_n_q;

    wire                      cs_hi;
    wire                      din;
    wire                      wide;
    wire                      low_s;
    wire                      rise;
    wire                      fall;
    wire [7:0]                cmd_nx;
    wire [15:0]               data_nx;
    wire                      cmd_done;
    wire                      dat_done;
    wire [5:0]                data_last;
    wire [7:0]                head_addr;
    wire [7:0]                base_addr;
    wire [15:0]               wdata;
    wire                      prog_go;
    wire                      erase_go;
    wire                      cmd_erase;
    wire                      cmd_unlock;
    wire                      cmd_lock;
    wire                      buf_clr;
    wire                      buf_in_valid;
    wire                      buf_in_ready;
    wire [15:0]               fetch_word;
    wire                      buf_out_valid;
    wire                      buf_out_ready;
    wire [15:0]               buf_out_data;
    integer                   i;

    assign serial_out      = so_q;
    assign serial_out_oe_n = oe_n_q;
    assign ready_status    = ready_q;

    // two flops on every pin; only the second stage is read below
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q <= `SEP_PIN_RST;
            pin_s2_q <= `SEP_PIN_RST;
            sclk_d_q <= 1'b1;
        end else begin
            pin_s1_q <= {cs_n, sclk, serial_in, word_width_select,
                         low_supply};
            pin_s2_q <= pin_s1_q;
            sclk_d_q <= pin_s2_q[`SEP_PIN_SCLK];
        end
    end

    assign cs_hi = pin_s2_q[`SEP_PIN_CS];
    assign din   = pin_s2_q[`SEP_PIN_DI];
    assign wide  = wide_q;
    assign low_s = pin_s2_q[`SEP_PIN_LOW];

    // width is frozen while selected: a pin moving mid-instruction
    // would otherwise split the address or data field
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wide_q <= 1'b0;
        end else if (cs_hi) begin
            wide_q <= pin_s2_q[`SEP_PIN_WIDE];
        end
    end

    // edges count only with select low
    assign rise = ~cs_hi & pin_s2_q[`SEP_PIN_SCLK] & ~sclk_d_q;
    assign fall = ~cs_hi & ~pin_s2_q[`SEP_PIN_SCLK] & sclk_d_q;

    // first bit on the wire ends in bit 0 of each field
    assign cmd_nx  = {din, cmd_sh_q[7:1]};
    assign data_nx = {din, data_sh_q[15:1]};

    assign cmd_done = rise & (st_q == ST_HEAD)
                      & (bit_cnt_q == `SEP_CMD_LAST);
    assign data_last = wide ? `SEP_DATA_LAST_WORD
                            : `SEP_DATA_LAST_BYTE;
    assign dat_done = rise & (st_q == ST_DATA) & (bit_cnt_q == data_last);

    // word mode drops the trailing zero of the address field
    assign head_addr = wide ? {addr_sh_q[6:0], 1'b0}
                            : addr_sh_q;
    assign base_addr = head_addr;

    // byte-mode data sits in the upper half after eight shifts
    assign wdata = wide ? data_nx : {8'h00, data_nx[15:8]};

    // one decode per code keeps the mode and timer logic in step
    assign cmd_erase  = cmd_done & (cmd_nx == `SEP_CMD_ERASE);
    assign cmd_unlock = cmd_done & (cmd_nx == `SEP_CMD_UNLOCK);
    assign cmd_lock   = cmd_done & (cmd_nx == `SEP_CMD_LOCK);

    // busy or locked requests are dropped, not queued
    assign prog_go  = dat_done & wen_q & ready_q;
    assign erase_go = cmd_erase & wen_q & ready_q;

    // instruction capture and read / status shifting
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q      <= ST_HEAD;
            bit_cnt_q <= 6'h00;
            addr_sh_q <= 8'h00;
            cmd_sh_q  <= 8'h00;
            data_sh_q <= 16'h0000;
            out_sh_q  <= 16'h0000;
            out_cnt_q <= 5'h00;
            so_q      <= 1'b1;
            oe_n_q    <= 1'b1;
        end else if (cs_hi) begin
            // deselect ends the instruction; a timed write keeps going
            st_q      <= ST_HEAD;
            bit_cnt_q <= 6'h00;
            out_cnt_q <= 5'h00;
            oe_n_q    <= 1'b1;
            so_q      <= 1'b1;
        end else begin
            if (rise) begin
                case (st_q)
                    ST_HEAD: begin
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                        if (bit_cnt_q < `SEP_ADDR_BITS) begin
                            addr_sh_q <= {din, addr_sh_q[7:1]};
                        end else begin
                            cmd_sh_q <= cmd_nx;
                        end
                        if (cmd_done) begin
                            case (cmd_nx)
                                `SEP_CMD_READ: begin
                                    st_q   <= ST_READ;
                                    oe_n_q <= 1'b0;
                                end
                                `SEP_CMD_PROGRAM: begin
                                    st_q <= ST_DATA;
                                end
                                `SEP_CMD_STATUS: begin
                                    st_q   <= ST_STAT;
                                    oe_n_q <= 1'b0;
                                    so_q   <= ready_q;
                                end
                                default: begin
                                    // erase, lock, unlock act elsewhere
                                    st_q <= ST_DONE;
                                end
                            endcase
                        end
                    end
                    ST_DATA: begin
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                        data_sh_q <= data_nx;
                        if (dat_done) begin
                            st_q <= ST_DONE;
                        end
                    end
                    default: begin
                        bit_cnt_q <= bit_cnt_q;
                    end
                endcase
            end
            if (fall) begin
                case (st_q)
                    ST_READ: begin
                        if (out_cnt_q != 5'h00) begin
                            so_q      <= out_sh_q[0];
                            out_sh_q  <= {1'b0, out_sh_q[15:1]};
                            out_cnt_q <= out_cnt_q - 5'h01;
                        end else if (buf_out_valid) begin
                            so_q      <= buf_out_data[0];
                            out_sh_q  <= {1'b0, buf_out_data[15:1]};
                            out_cnt_q <= wide ? `SEP_SHIFT_WORD
                                              : `SEP_SHIFT_BYTE;
                        end
                    end
                    ST_STAT: begin
                        so_q <= ready_q;
                    end
                    default: begin
                        so_q <= so_q;
                    end
                endcase
            end
        end
    end

    // write mode; a sagging supply overrides any unlock
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wen_q <= `SEP_WEN_RST;
        end else if (low_s) begin
            wen_q <= 1'b0;
        end else if (cmd_unlock) begin
            wen_q <= 1'b1;
        end else if (cmd_lock) begin
            wen_q <= 1'b0;
        end
    end

    // self timer; runs on regardless of select
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ready_q <= 1'b1;
            tmr_q   <= {`SEP_TIMER_W{1'b0}};
        end else if (prog_go | erase_go) begin
            ready_q <= 1'b0;
            tmr_q   <= WRITE_CYCLES;
        end else if (!ready_q) begin
            if (tmr_q <= {{(`SEP_TIMER_W-1){1'b0}}, 1'b1}) begin
                ready_q <= 1'b1;
            end else begin
                tmr_q <= tmr_q - {{(`SEP_TIMER_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // storage has no reset: contents are meant to persist
    always @(posedge sys_clk) begin
        if (erase_go) begin
            for (i = 0; i < `SEP_MEM_BYTES; i = i + 1) begin
                mem_q[i] <= `SEP_ERASED;
            end
        end else if (prog_go) begin
            mem_q[base_addr] <= wdata[7:0];
            if (wide) begin
                mem_q[base_addr | 8'h01] <= wdata[15:8];
            end
        end
    end

    // read fetch: successive words are prefetched while select stays low
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fetch_addr_q <= 8'h00;
        end else if (cmd_done) begin
            fetch_addr_q <= base_addr;
        end else if (buf_in_valid & buf_in_ready) begin
            fetch_addr_q <= fetch_addr_q + (wide ? 8'h02 : 8'h01);
        end
    end

    // word fetch forces an even low-byte index
    assign fetch_word = wide ? {mem_q[fetch_addr_q | 8'h01],
                                mem_q[fetch_addr_q & 8'hfe]}
                             : {8'h00, mem_q[fetch_addr_q]};

    // a fresh command drops any words fetched for the one before
    assign buf_clr       = cs_hi | cmd_done;
    assign buf_in_valid  = (st_q == ST_READ) & ~cs_hi;
    assign buf_out_ready = fall & (st_q == ST_READ) & (out_cnt_q == 5'h00);

    // two entries cover the fetch latency, so no fall finds it empty
    sep_buf2 #(
        .W     (`SEP_BUF_W),
        .DEPTH (`SEP_BUF_DEPTH),
        .AW    (`SEP_BUF_AW)
    ) u_buf (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .clr       (buf_clr),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (fetch_word),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

endmodule

//--- sep_props.sv
// pin-level assertions for the serial memory command port
`timescale 1ns/10ps
module sep_props #(
    parameter int WRITE_CYCLES = 400
) (
    // clock and reset
    input wire sys_clk,
    input wire arst_n,
    // pins
    input wire cs_n,
    input wire sclk,
    input wire serial_out,
    input wire serial_out_oe_n,
    input wire low_supply,
    input wire ready_status
);
    localparam int BUSY_MAX = WRITE_CYCLES + 8;
    logic [23:0] busy_q;
    logic [3:0]  low_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // busy length, and cycles since the serial clock was last seen low
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 24'h00_0000;
            low_q  <= 4'hf;
        end else begin
            busy_q <= ready_status ? 24'h00_0000 : busy_q + 24'h00_0001;
            low_q  <= !sclk ? 4'h0 : low_q + {3'h0, low_q != 4'hf};
        end
    end
    sequence s_busy_start;
        $fell(ready_status);
    endsequence
    sequence s_busy_end;
        ##[1:BUSY_MAX] ready_status;
    endsequence
    property p_busy_bounded;
        s_busy_start |-> s_busy_end;
    endproperty
    a_busy_bounded: assert property (p_busy_bounded)
        else $error("write did not finish in time");
    property p_busy_exact;
        $rose(ready_status) |-> busy_q == WRITE_CYCLES;
    endproperty
    a_busy_exact: assert property (p_busy_exact)
        else $error("busy time wrong");
    property p_busy_low_supply;
        s_busy_start |-> !$past(low_supply, 4);
    endproperty
    a_busy_low_supply: assert property (p_busy_low_supply)
        else $error("write started on low supply");
    property p_busy_sel;
        s_busy_start |-> !$past(cs_n, 5);
    endproperty
    a_busy_sel: assert property (p_busy_sel)
        else $error("write started while deselected");
    property p_oe_sel;
        $fell(serial_out_oe_n) |-> !$past(cs_n, 6);
    endproperty
    a_oe_sel: assert property (p_oe_sel)
        else $error("output enabled while deselected");
    property p_float_desel;
        cs_n [*8] |-> serial_out_oe_n;
    endproperty
    a_float_desel: assert property (p_float_desel)
        else $error("output driven while deselected");
    property p_idle_high;
        serial_out_oe_n |-> serial_out;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("idle output not high");
    property p_out_on_fall;
        !serial_out_oe_n && !$past(serial_out_oe_n) && $changed(serial_out)
            |-> low_q <= 4'h6;
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("output changed away from a clock fall");
endmodule
bind sep_cmd_port sep_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .low_supply(low_supply), .ready_status(ready_status));

//--- sep_host.sv
// host model: drives select, serial clock and data, captures serial_out
`timescale 1ns/10ps
module sep_host (
    // clock
    input  wire         sys_clk,
    // serial pins
    output logic        cs_n,
    output logic        sclk,
    output logic        serial_in,
    input  wire         serial_out,
    // captured read bits
    output logic [15:0] rd_word,
    output int          rd_cnt
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        serial_in = 1'b0;
        rd_word = 16'h0000;
        rd_cnt = 0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // bits: address in [7:0], command in [15:8], write data above
    task automatic frame(input logic [31:0] bits, input int n,
                         input int nrd);
        logic [15:0] cap;
        cap = 16'h0000;
        step(1);
        cs_n = 1'b0;
        step(4);
        for (int i = 0; i < n; i++) begin
            if (i > 16)
                cap[i-17] = serial_out;
            sclk = 1'b0;
            serial_in = bits[i];
            step(4);
            sclk = 1'b1;
            step(4);
            // clock held high mid-frame stalls the shifter
            if (i == 20)
                step(40);
        end
        if (n > 16)
            cap[n-17] = serial_out;
        step(4);
        cs_n = 1'b1;
        serial_in = ~serial_in;  // a released line must not keep its value
        if (nrd > 0) begin
            rd_word = cap;
            rd_cnt++;
        end
        step(8);
    endtask
endmodule

//--- sep_cmd_port_tb.sv
// self-checking bench for the serial memory command port
`timescale 1ns/10ps
`include "sep_defs.vh"
module sep_cmd_port_tb;
    localparam [21:0] WCYC = 22'h00_0190;  // shortened write time
    localparam [31:0] STAT = {16'h0000, `SEP_CMD_STATUS, 8'h00};
    localparam logic [7:0] BAD [3] = '{8'h00, 8'h02, 8'hff};
    logic        sys_clk, arst_n, word_width_select, low_supply;
    wire         cs_n, sclk, serial_in, serial_out, serial_out_oe_n;
    wire         ready_status;
    logic [15:0] rd_word, d;
    logic [7:0]  a;
    logic [7:0]  mem[256];
    logic [15:0] exp_q[$];
    int          rd_cnt, mismatches, checked, cycles;
    sep_cmd_port #(.WRITE_CYCLES(WCYC)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .low_supply(low_supply),
        .word_width_select(word_width_select), .ready_status(ready_status));
    sep_host host (
        .sys_clk(sys_clk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .rd_word(rd_word), .rd_cnt(rd_cnt));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // watcher: each captured word is compared with the oldest note
    always @(rd_cnt) begin
        // let the port copies of the captured word settle first
        #1;
        chk("serial_out", exp_q.size() ? exp_q.pop_front() : ~rd_word,
            rd_word);
        chk("oe_n", 16'h0000, {15'h0000, serial_out_oe_n});
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            summarize;
        end
    end
    function automatic logic [7:0] fld(input logic [7:0] b);
        return word_width_select ? {1'b0, b[7:1]} : b;
    endfunction
    task automatic wait_rdy;
        int k;
        k = 0;
        while (ready_status !== 1'b1 && k < 1000) begin
            host.step(1);
            k++;
        end
        chk("ready_status", 16'h0001, {15'h0000, ready_status});
    endtask
    // busy shows on the pin and through status, then clears
    task automatic probe(input bit eff);
        chk("ready_status", {15'h0000, !eff},
            {15'h0000, ready_status});
        if (eff) begin
            exp_q.push_back(16'h0000);
            host.frame(STAT, 24, 8);
            wait_rdy;
            exp_q.push_back(16'h00ff);
            host.frame(STAT, 24, 8);
        end
    endtask
    task automatic prog(input logic [7:0] b, input logic [15:0] dt,
                        input bit eff);
        host.frame({dt, `SEP_CMD_PROGRAM, fld(b)},
                   word_width_select ? 32 : 24, 0);
        if (eff) begin
            mem[b] = dt[7:0];
            if (word_width_select)
                mem[b+8'h01] = dt[15:8];
        end
        probe(eff);
    endtask
    task automatic erase(input bit eff);
        host.frame({16'h0000, `SEP_CMD_ERASE, 8'h5a}, 16, 0);
        if (eff)
            foreach (mem[i])
                mem[i] = `SEP_ERASED;
        probe(eff);
    endtask
    task automatic rd(input logic [7:0] b, input int nb);
        logic [15:0] e;
        e = {mem[b+8'h01], mem[b]};
        if (nb == 8)
            e[15:8] = 8'h00;
        exp_q.push_back(e);
        host.frame({16'h0000, `SEP_CMD_READ, fld(b)}, 16 + nb, nb);
        chk("oe_n", 16'h0001, {15'h0000, serial_out_oe_n});
    endtask
    initial begin
        arst_n = 1'b0;
        word_width_select = 1'b0;
        low_supply = 1'b0;
        void'($urandom(32'ha0cc_0659));
        repeat (16) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        host.step(8);  // shortened power-up wait
        chk("ready_status", 16'h0001, {15'h0000, ready_status});
        chk("oe_n", 16'h0001, {15'h0000, serial_out_oe_n});
        host.frame({16'h0000, `SEP_CMD_UNLOCK, 8'h3c}, 16, 0);
        erase(1'b1);
        for (int k = 0; k < 4; k++) begin
            word_width_select = 1'($urandom);
            a = 8'($urandom) & (word_width_select ? 8'hfe : 8'hff);
            d = 16'($urandom);
            prog(a, d, 1'b1);
            rd(a, word_width_select ? 16 : 8);
            // earlier unit, then in byte mode the programmed byte through the buffer, with a clock stall
            rd(a - (word_width_select ? 8'h02 : 8'h01), 16);
        end
        word_width_select = 1'b1;
        a = 8'($urandom) & 8'hfe;
        prog(a, d, 1'b1);
        rd(a, 16);
        word_width_select = 1'b0;
        low_supply = 1'b1;
        host.step(4);
        prog(a, ~d, 1'b0);
        low_supply = 1'b0;
        rd(a, 8);
        host.frame({16'h0000, `SEP_CMD_LOCK, 8'hc3}, 16, 0);
        prog(a, ~d, 1'b0);
        erase(1'b0);
        host.frame({16'h0000, `SEP_CMD_UNLOCK, 8'h96}, 16, 0);
        foreach (BAD[i]) begin
            host.frame({16'h0000, BAD[i], 8'h11}, 24, 0);
            chk("ready_status", 16'h0001, {15'h0000, ready_status});
        end
        prog(a, ~d, 1'b1);
        rd(a, 8);
        host.step(8);
        chk("queue", 16'h0000, 16'(exp_q.size()));
        summarize;
    end
endmodule
